// ### design/csb_pkg.sv
`default_nettype none
package csb_pkg;
  // widths
  localparam int DATA_W = 8;
  localparam int PC_W = 16;
  localparam int K_W = 7;
  localparam int OP_W = 4;
  localparam int SEL_W = 3;
  localparam int CYC_W = 2;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_INSTR = 8'h04;
  localparam logic [7:0] OFF_OPND = 8'h08;
  localparam logic [7:0] OFF_PC = 8'h0c;
  localparam logic [7:0] OFF_FLAGS = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  // control and status fields
  localparam int CTRL_START_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_TAKEN_BIT = 1;
  localparam int STAT_CYC_LSB = 2;
  // instruction word fields
  localparam int INSTR_OP_LSB = 0;
  localparam int INSTR_SEL_LSB = 4;
  localparam int INSTR_K_LSB = 7;
  localparam int INSTR_TWO_BIT = 14;
  // operand word fields
  localparam int OPND_RD_LSB = 0;
  localparam int OPND_RR_LSB = 8;
  localparam int OPND_IMM_LSB = 16;
  localparam int OPND_IO_LSB = 24;
  // flag positions in the status flags register
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  // operation codes
  localparam logic [3:0] OP_COMPARE = 4'h0;
  localparam logic [3:0] OP_COMPARE_WITH_BORROW = 4'h1;
  localparam logic [3:0] OP_COMPARE_IMMEDIATE = 4'h2;
  localparam logic [3:0] OP_COMPARE_SKIP_EQUAL = 4'h3;
  localparam logic [3:0] OP_SKIP_REG_BIT_CLEAR = 4'h4;
  localparam logic [3:0] OP_SKIP_REG_BIT_SET = 4'h5;
  localparam logic [3:0] OP_SKIP_IO_BIT_CLEAR = 4'h6;
  localparam logic [3:0] OP_SKIP_IO_BIT_SET = 4'h7;
  localparam logic [3:0] OP_BRANCH_FLAG_SET = 4'h8;
  localparam logic [3:0] OP_BRANCH_FLAG_CLEAR = 4'h9;
  localparam logic [3:0] OP_BRANCH_ON_EQUAL = 4'ha;
  localparam logic [3:0] OP_BRANCH_ON_UNEQUAL = 4'hb;
  localparam logic [3:0] OP_BRANCH_ON_CARRY = 4'hc;
  localparam logic [3:0] OP_BRANCH_ON_NO_CARRY = 4'hd;
  localparam logic [3:0] OP_BRANCH_UNSIGNED_GE = 4'he;
  // reset values
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  // program counter steps and cycle counts
  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam logic [15:0] PC_SKIP_ONE = 16'h0002;
  localparam logic [15:0] PC_SKIP_TWO = 16'h0003;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;
endpackage
`default_nettype wire

// ### design/exec_if.sv
`timescale 1ns/1ps
`default_nettype none
interface exec_if;
  logic [3:0] op;
  logic [7:0] rd;
  logic [7:0] rr;
  logic [7:0] imm;
  logic [7:0] io_val;
  logic [2:0] bit_sel;
  logic [6:0] k;
  logic two_word;
  logic [15:0] pc;
  logic [7:0] flags;
  logic [7:0] new_flags;
  logic flags_we;
  logic taken;
  logic [15:0] new_pc;
  logic [1:0] cycles;
  modport core (
    output op, rd, rr, imm, io_val, bit_sel, k, two_word, pc, flags,
    input new_flags, flags_we, taken, new_pc, cycles
  );
  modport alu (
    input op, rd, rr, imm, flags,
    output new_flags, flags_we
  );
  modport seq (
    input op, rd, rr, io_val, bit_sel, k, two_word, pc, flags,
    output taken, new_pc, cycles
  );
endinterface
`default_nettype wire

// ### design/flag_compare.sv
`timescale 1ns/1ps
`default_nettype none
module flag_compare (
  // operands and flag results
  exec_if.alu ex
);
  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] diff;
  logic cin;
  logic keep_z;
  logic we;
  logic vf;
  logic nf;

  always_comb
  begin
    a = ex.rd;
    b = ex.rr;
    cin = 1'b0;
    keep_z = 1'b0;
    we = 1'b0;
    case (ex.op)
      csb_pkg::OP_COMPARE:
      begin
        we = 1'b1;
      end
      csb_pkg::OP_COMPARE_WITH_BORROW:
      begin
        we = 1'b1;
        cin = ex.flags[csb_pkg::FLAG_C];
        keep_z = 1'b1;
      end
      csb_pkg::OP_COMPARE_IMMEDIATE:
      begin
        we = 1'b1;
        b = ex.imm;
      end
      default:
      begin
        we = 1'b0;
      end
    endcase
    diff = a - b - {7'h00, cin};
    nf = diff[7];
    vf = (a[7] & ~b[7] & ~diff[7]) | (~a[7] & b[7] & diff[7]);
    ex.new_flags = ex.flags;
    ex.flags_we = we;
    if (we)
    begin
      ex.new_flags[csb_pkg::FLAG_Z] = (diff == 8'h00)
        & (~keep_z | ex.flags[csb_pkg::FLAG_Z]);
      ex.new_flags[csb_pkg::FLAG_N] = nf;
      ex.new_flags[csb_pkg::FLAG_V] = vf;
      ex.new_flags[csb_pkg::FLAG_S] = nf ^ vf;
      ex.new_flags[csb_pkg::FLAG_C] = (~a[7] & b[7]) | (b[7] & diff[7])
        | (diff[7] & ~a[7]);
      ex.new_flags[csb_pkg::FLAG_H] = (~a[3] & b[3]) | (b[3] & diff[3])
        | (diff[3] & ~a[3]);
    end
  end
endmodule
`default_nettype wire

// ### design/skip_branch_eval.sv
`timescale 1ns/1ps
`default_nettype none
module skip_branch_eval (
  // operands and sequencing results
  exec_if.seq ex
);
  logic skip;
  logic branch;
  logic [15:0] k_ext;
  logic [15:0] br_pc;
  logic [15:0] skip_pc;

  always_comb
  begin
    skip = 1'b0;
    branch = 1'b0;
    k_ext = {{9{ex.k[6]}}, ex.k};
    br_pc = ex.pc + k_ext + csb_pkg::PC_STEP;
    skip_pc = ex.two_word ? ex.pc + csb_pkg::PC_SKIP_TWO
                          : ex.pc + csb_pkg::PC_SKIP_ONE;
    case (ex.op)
      csb_pkg::OP_COMPARE_SKIP_EQUAL: skip = (ex.rd == ex.rr);
      csb_pkg::OP_SKIP_REG_BIT_CLEAR: skip = ~ex.rd[ex.bit_sel];
      csb_pkg::OP_SKIP_REG_BIT_SET: skip = ex.rd[ex.bit_sel];
      csb_pkg::OP_SKIP_IO_BIT_CLEAR: skip = ~ex.io_val[ex.bit_sel];
      csb_pkg::OP_SKIP_IO_BIT_SET: skip = ex.io_val[ex.bit_sel];
      csb_pkg::OP_BRANCH_FLAG_SET: branch = ex.flags[ex.bit_sel];
      csb_pkg::OP_BRANCH_FLAG_CLEAR: branch = ~ex.flags[ex.bit_sel];
      csb_pkg::OP_BRANCH_ON_EQUAL: branch = ex.flags[csb_pkg::FLAG_Z];
      csb_pkg::OP_BRANCH_ON_UNEQUAL: branch = ~ex.flags[csb_pkg::FLAG_Z];
      csb_pkg::OP_BRANCH_ON_CARRY: branch = ex.flags[csb_pkg::FLAG_C];
      csb_pkg::OP_BRANCH_ON_NO_CARRY: branch = ~ex.flags[csb_pkg::FLAG_C];
      csb_pkg::OP_BRANCH_UNSIGNED_GE: branch = ~ex.flags[csb_pkg::FLAG_C];
      default: skip = 1'b0;
    endcase
    ex.taken = skip | branch;
    if (skip)
    begin
      ex.new_pc = skip_pc;
      ex.cycles = ex.two_word ? csb_pkg::CYC_THREE : csb_pkg::CYC_TWO;
    end
    else if (branch)
    begin
      ex.new_pc = br_pc;
      ex.cycles = csb_pkg::CYC_TWO;
    end
    else
    begin
      ex.new_pc = ex.pc + csb_pkg::PC_STEP;
      ex.cycles = csb_pkg::CYC_ONE;
    end
  end
endmodule
`default_nettype wire

// ### design/compare_skip_branch_unit.sv
// Functional notes
// - Compare with constant sets Z N V S C H and drops the difference.
// - Compare-then-skip skips the next instruction when rd equals rr.
// - Skip on clear register bit advances the counter by 2 or 3.
// - Skip on set register bit advances the counter by 2 or 3.
// - Skip on clear io bit advances by 2 or 3 and leaves flags alone.
// - Skip on set io bit advances by 2 or 3 and leaves flags alone.
// - Branch on set flag loads pc plus offset plus one.
// - Branch on clear flag jumps to pc plus offset plus one, flags kept.
// - Branch on no carry is taken only while carry is zero.
// - Unsigned same-or-higher branch is taken when carry is zero.
`timescale 1ns/1ps
`default_nettype none
module compare_skip_branch_unit #(
  parameter int ADDR_W = 8
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // execution state
  output logic busy
);
  typedef enum logic [0:0] {st_idle, st_exec} state_e;

  state_e state_reg;
  logic [31:0] instr_reg;
  logic [31:0] opnd_reg;
  logic [15:0] pc_reg;
  logic [7:0] flags_reg;
  logic [1:0] cnt_reg;
  logic [15:0] pend_pc_reg;
  logic [7:0] pend_flags_reg;
  logic pend_taken_reg;
  logic [1:0] pend_cyc_reg;
  logic taken_reg;
  logic [1:0] cyc_reg;
  logic [31:0] rd_next;
  logic addr_ok;
  logic [7:0] addr8;
  logic wr_acc;
  logic start;
  logic commit;

  exec_if ex ();

  flag_compare u_flags (
    .ex (ex)
  );

  skip_branch_eval u_seq (
    .ex (ex)
  );

  assign ex.op = instr_reg[csb_pkg::INSTR_OP_LSB +: csb_pkg::OP_W];
  assign ex.bit_sel = instr_reg[csb_pkg::INSTR_SEL_LSB +: csb_pkg::SEL_W];
  assign ex.k = instr_reg[csb_pkg::INSTR_K_LSB +: csb_pkg::K_W];
  assign ex.two_word = instr_reg[csb_pkg::INSTR_TWO_BIT];
  assign ex.rd = opnd_reg[csb_pkg::OPND_RD_LSB +: csb_pkg::DATA_W];
  assign ex.rr = opnd_reg[csb_pkg::OPND_RR_LSB +: csb_pkg::DATA_W];
  assign ex.imm = opnd_reg[csb_pkg::OPND_IMM_LSB +: csb_pkg::DATA_W];
  assign ex.io_val = opnd_reg[csb_pkg::OPND_IO_LSB +: csb_pkg::DATA_W];
  assign ex.pc = pc_reg;
  assign ex.flags = flags_reg;

  assign addr8 = paddr[7:0];
  assign pready = 1'b1;
  assign wr_acc = psel & penable & pwrite & ce & addr_ok;
  assign busy = (state_reg == st_exec);
  assign start = wr_acc & addr_ok & (addr8 == csb_pkg::OFF_CTRL)
    & pwdata[csb_pkg::CTRL_START_BIT] & (state_reg == st_idle);
  assign commit = ce & (state_reg == st_exec) & (cnt_reg == 2'h0);

  // address decode and read data
  always_comb
  begin
    addr_ok = 1'b1;
    rd_next = 32'h0000_0000;
    if (addr8 == csb_pkg::OFF_CTRL)
      rd_next = 32'h0000_0000;
    else if (addr8 == csb_pkg::OFF_INSTR)
      rd_next = instr_reg;
    else if (addr8 == csb_pkg::OFF_OPND)
      rd_next = opnd_reg;
    else if (addr8 == csb_pkg::OFF_PC)
      rd_next = {16'h0000, pc_reg};
    else if (addr8 == csb_pkg::OFF_FLAGS)
      rd_next = {24'h00_0000, flags_reg};
    else if (addr8 == csb_pkg::OFF_STATUS)
      rd_next = {28'h000_0000, cyc_reg, taken_reg, busy};
    else
      addr_ok = 1'b0;
    // bits above the byte offset must be zero
    if ((paddr >> 8) != '0)
      addr_ok = 1'b0;
  end

  assign pslverr = psel & penable & ~addr_ok;

  // read data captured in the setup cycle
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      prdata <= csb_pkg::WORD_RST;
    else if (ce && psel && !penable && !pwrite)
      prdata <= addr_ok ? rd_next : csb_pkg::WORD_RST;
  end

  // instruction and operand words
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      instr_reg <= csb_pkg::WORD_RST;
      opnd_reg <= csb_pkg::WORD_RST;
    end
    else if (wr_acc && state_reg == st_idle)
    begin
      if (addr8 == csb_pkg::OFF_INSTR)
        instr_reg <= pwdata;
      else if (addr8 == csb_pkg::OFF_OPND)
        opnd_reg <= pwdata;
    end
  end

  // execution sequencer
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= st_idle;
      cnt_reg <= 2'h0;
    end
    else if (ce)
    begin
      case (state_reg)
        st_idle:
          if (start)
          begin
            state_reg <= st_exec;
            // busy for the outcome's cycle count
            cnt_reg <= ex.cycles - 2'h1;
          end
        st_exec:
          if (cnt_reg == 2'h0)
            state_reg <= st_idle;
          else
            cnt_reg <= cnt_reg - 2'h1;
        default:
          state_reg <= st_idle;
      endcase
    end
  end

  // results held until the last cycle
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pend_pc_reg <= csb_pkg::PC_RST;
      pend_flags_reg <= csb_pkg::FLAGS_RST;
      pend_taken_reg <= 1'b0;
      pend_cyc_reg <= 2'h0;
    end
    else if (start)
    begin
      pend_pc_reg <= ex.new_pc;
      pend_flags_reg <= ex.new_flags;
      pend_taken_reg <= ex.taken;
      pend_cyc_reg <= ex.cycles;
    end
  end

  // program counter and flags
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pc_reg <= csb_pkg::PC_RST;
      flags_reg <= csb_pkg::FLAGS_RST;
      taken_reg <= 1'b0;
      cyc_reg <= 2'h0;
    end
    else if (commit)
    begin
      pc_reg <= pend_pc_reg;
      flags_reg <= pend_flags_reg;
      taken_reg <= pend_taken_reg;
      cyc_reg <= pend_cyc_reg;
    end
    else if (wr_acc && state_reg == st_idle)
    begin
      if (addr8 == csb_pkg::OFF_PC)
        pc_reg <= pwdata[15:0];
      else if (addr8 == csb_pkg::OFF_FLAGS)
        flags_reg <= pwdata[7:0];
    end
  end

  a_cmp_imm_flags: assert property (@(posedge clk)
    disable iff (!rstn)
    start && ex.op == csb_pkg::OP_COMPARE_IMMEDIATE |->
      ex.flags_we && ex.new_flags[csb_pkg::FLAG_Z] == (ex.rd == ex.imm)
      && ex.new_flags[csb_pkg::FLAG_C] == (ex.rd < ex.imm))
    else $error("immediate compare flags wrong");

  a_cpse_skip_eq: assert property (@(posedge clk)
    disable iff (!rstn)
    start && ex.op == csb_pkg::OP_COMPARE_SKIP_EQUAL |->
      ex.taken == (ex.rd == ex.rr))
    else $error("compare skip decision wrong");

  a_reg_clear_pc: assert property (@(posedge clk)
    disable iff (!rstn)
    start && ex.op == csb_pkg::OP_SKIP_REG_BIT_CLEAR
      && !ex.rd[ex.bit_sel] |->
      ex.new_pc == pc_reg + (ex.two_word ? 16'h0003 : 16'h0002))
    else $error("register bit clear skip target wrong");

  a_reg_set_pc: assert property (@(posedge clk)
    disable iff (!rstn)
    start && ex.op == csb_pkg::OP_SKIP_REG_BIT_SET |->
      ex.new_pc == (ex.rd[ex.bit_sel]
        ? pc_reg + (ex.two_word ? 16'h0003 : 16'h0002)
        : pc_reg + 16'h0001))
    else $error("register bit set skip target wrong");

  a_io_clear_flags: assert property (@(posedge clk)
    disable iff (!rstn)
    start && ex.op == csb_pkg::OP_SKIP_IO_BIT_CLEAR |->
      !ex.flags_we && ex.taken == !ex.io_val[ex.bit_sel]
      ##1 (pend_flags_reg == $past(flags_reg)))
    else $error("io bit clear skip wrong or flags changed");

  a_io_set_skip: assert property (@(posedge clk)
    disable iff (!rstn)
    start && ex.op == csb_pkg::OP_SKIP_IO_BIT_SET
      && ex.io_val[ex.bit_sel] |->
      ex.taken && !ex.flags_we
      && ex.cycles == (ex.two_word ? 2'h3 : 2'h2))
    else $error("io bit set skip wrong");

  a_flag_set_br: assert property (@(posedge clk)
    disable iff (!rstn)
    start && ex.op == csb_pkg::OP_BRANCH_FLAG_SET
      && flags_reg[ex.bit_sel] |->
      ex.new_pc == pc_reg + {{9{ex.k[6]}}, ex.k} + 16'h0001)
    else $error("branch on set flag target wrong");

  a_flag_clr_br: assert property (@(posedge clk)
    disable iff (!rstn)
    start && ex.op == csb_pkg::OP_BRANCH_FLAG_CLEAR |->
      ex.taken == !flags_reg[ex.bit_sel] && !ex.flags_we)
    else $error("branch on clear flag wrong");

  a_no_carry_br: assert property (@(posedge clk)
    disable iff (!rstn)
    start && ex.op == csb_pkg::OP_BRANCH_ON_NO_CARRY
      && flags_reg[csb_pkg::FLAG_C] |->
      !ex.taken && ex.new_pc == pc_reg + 16'h0001)
    else $error("carry set must fall through");

  a_unsigned_ge: assert property (@(posedge clk)
    disable iff (!rstn)
    start && ex.op == csb_pkg::OP_BRANCH_UNSIGNED_GE |->
      ex.taken == !flags_reg[csb_pkg::FLAG_C])
    else $error("same-or-higher branch decision wrong");

  a_cycle_commit: assert property (@(posedge clk)
    disable iff (!rstn)
    start && ce && ex.cycles == 2'h1 ##1 ce |=>
      state_reg == st_idle && pc_reg == $past(pend_pc_reg))
    else $error("one-cycle operation did not commit");

  a_taken_two: assert property (@(posedge clk)
    disable iff (!rstn)
    start && ex.op >= csb_pkg::OP_BRANCH_FLAG_SET |->
      ex.cycles == (ex.taken ? 2'h2 : 2'h1))
    else $error("branch cycle count wrong");

  a_back_offset: assert property (@(posedge clk)
    disable iff (!rstn)
    start && ex.op == csb_pkg::OP_BRANCH_FLAG_SET && ex.k[6]
      && flags_reg[ex.bit_sel] |->
      ex.new_pc == pc_reg + 16'h0001 - {9'h000, 7'h00 - ex.k})
    else $error("negative offset not sign extended");

  a_commit_idle: assert property (@(posedge clk)
    disable iff (!rstn)
    commit |=> !busy && pc_reg == $past(pend_pc_reg)
      && flags_reg == $past(pend_flags_reg))
    else $error("commit did not end execution");

  a_exec_frozen: assert property (@(posedge clk)
    disable iff (!rstn)
    busy && !commit |=> $stable(pc_reg) && $stable(flags_reg))
    else $error("pc or flags changed mid execution");
endmodule
`default_nettype wire

// ### tb/compare_skip_branch_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module compare_skip_branch_unit_tb;
  logic clk;
  logic rstn;
  logic ce;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic busy;
  logic [32:0] exp_rd[$];
  logic [31:0] exp_cy[$];
  int fails;
  int checks;
  int seed;
  int cnt;

  compare_skip_branch_unit i_compare_skip_branch_unit (
    .clk(clk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .busy(busy)
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic close_out();
    $display("counts: checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_cyc(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // read results: pslverr and prdata, taken at the access edge
  always @(posedge clk)
  begin
    if (psel && penable && pready && !pwrite)
    begin
      if (exp_rd.size() == 0)
        check({pslverr, prdata}, 33'h1_dead_beef);
      else
        check({pslverr, prdata}, exp_rd.pop_front());
    end
  end

  // execution length: cycles with busy high
  always @(negedge clk)
  begin
    if (busy === 1'b1)
      cnt++;
    else if (cnt != 0)
    begin
      check_cyc(32'(cnt), exp_cy.pop_front());
      cnt = 0;
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_rd.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  function automatic logic [7:0] subf(input logic [7:0] a, input logic [7:0] b,
    input logic cin, input logic [7:0] f, input logic kz);
    int d;
    int s;
    logic [7:0] r;
    logic h;
    logic v;
    logic z;
    d = int'(a) - int'(b) - int'(cin);
    s = int'($signed(a)) - int'($signed(b)) - int'(cin);
    r = d[7:0];
    // borrows and overflow from plain integer arithmetic
    h = (int'(a[3:0]) - int'(b[3:0]) - int'(cin)) < 0;
    v = (s > 127) || (s < -128);
    z = (r == 8'h00) && (!kz || f[1]);
    return {f[7:6], h, r[7] ^ v, v, r[7], z, d < 0};
  endfunction

  task automatic run(input logic [3:0] op, input logic [2:0] sel,
    input logic [6:0] k, input logic two, input logic [31:0] od,
    input logic [15:0] pc, input logic [7:0] fl);
    logic [7:0] ef;
    logic [15:0] ep;
    logic tk;
    logic cnd;
    logic [1:0] cy;
    ef = fl;
    tk = 1'b0;
    ep = pc + 16'h0001;
    cy = 2'h1;
    cnd = 1'b0;
    case (op)
      4'h0: ef = subf(od[7:0], od[15:8], 1'b0, fl, 1'b0);
      4'h1: ef = subf(od[7:0], od[15:8], fl[0], fl, 1'b1);
      4'h2: ef = subf(od[7:0], od[23:16], 1'b0, fl, 1'b0);
      4'h3: cnd = od[7:0] == od[15:8];
      4'h4: cnd = !od[sel];
      4'h5: cnd = od[sel];
      4'h6: cnd = !od[24 + sel];
      4'h7: cnd = od[24 + sel];
      4'h8: cnd = fl[sel];
      4'h9: cnd = !fl[sel];
      4'ha: cnd = fl[1];
      4'hb: cnd = !fl[1];
      4'hc: cnd = fl[0];
      4'hd, 4'he: cnd = !fl[0];
      default: cnd = 1'b0;
    endcase
    if (cnd)
    begin
      tk = 1'b1;
      cy = (op < 4'h8) ? (two ? 2'h3 : 2'h2) : 2'h2;
      ep = (op < 4'h8) ? pc + {14'h0, cy} : pc + {{9{k[6]}}, k} + 16'h0001;
    end
    apb(1'b1, csb_pkg::OFF_INSTR, {17'h0, two, k, sel, op});
    apb(1'b1, csb_pkg::OFF_OPND, od);
    apb(1'b1, csb_pkg::OFF_PC, {16'h0, pc});
    apb(1'b1, csb_pkg::OFF_FLAGS, {24'h0, fl});
    exp_cy.push_back({30'h0, cy});
    apb(1'b1, csb_pkg::OFF_CTRL, 32'h0000_0001);
    @(negedge clk);
    while (busy !== 1'b0)
      @(negedge clk);
    @(posedge clk);
    rd(csb_pkg::OFF_PC, {17'h0, ep});
    rd(csb_pkg::OFF_FLAGS, {25'h0, ef});
    rd(csb_pkg::OFF_STATUS, {29'h0, cy, tk, 1'b0});
  endtask

  initial
  begin
    logic [31:0] od;
    int i;
    seed = 89092;
    cnt = 0;
    fails = 0;
    checks = 0;
    rstn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(csb_pkg::OFF_PC, 33'h0);
    rd(csb_pkg::OFF_FLAGS, 33'h0);
    rd(csb_pkg::OFF_STATUS, 33'h0);
    rd(csb_pkg::OFF_OPND, 33'h0);
    rd(8'h20, 33'h1_0000_0000);
    apb(1'b1, csb_pkg::OFF_OPND, 32'hc3a5_5a3c);
    rd(csb_pkg::OFF_OPND, 33'h0_c3a5_5a3c);
    ce <= 1'b0;
    apb(1'b1, csb_pkg::OFF_PC, 32'h0000_5a5a);
    ce <= 1'b1;
    rd(csb_pkg::OFF_PC, 33'h0);
    $display("test registers done");
    run(4'h3, 3'h0, 7'h00, 1'b1, 32'h0000_4242, 16'hfffe, 8'h00);
    run(4'h2, 3'h0, 7'h00, 1'b0, 32'h0080_0080, 16'h0010, 8'hc0);
    run(4'h1, 3'h0, 7'h00, 1'b0, 32'h0000_1112, 16'h0010, 8'h01);
    run(4'h8, 3'h5, 7'h40, 1'b0, 32'h0, 16'h0003, 8'h20);
    run(4'hd, 3'h0, 7'h3f, 1'b0, 32'h0, 16'hffc0, 8'h00);
    run(4'he, 3'h0, 7'h05, 1'b0, 32'h0, 16'h0100, 8'h01);
    $display("test directed done");
    for (i = 0; i < 64; i++)
    begin
      od = $random(seed);
      if (i % 32 == 3)
        od[15:8] = od[7:0];
      run(i[3:0], 3'($random(seed)), 7'($random(seed)), 1'($random(seed)),
        od, 16'($random(seed)), 8'($random(seed)));
    end
    $display("test random done");
    close_out();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    close_out();
  end
endmodule
`default_nettype wire
